//--- dv/dtc_asserts.sv
// Checker for the register port and baud output of the dual timer
`timescale 1ns/1ns
module dtc_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire baud_tick
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and address decode seen from outside
	wire acc = psel && penable;
	wire hit = paddr inside {12'h220, 12'h224, 12'h228, 12'h22C, 12'h230, 12'h234,
		12'h2A0, 12'h2B0};
	// Timer 1 overflows come at most once per six-clock tick
	sequence s_quiet;
		!baud_tick [*5];
	endsequence
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
	a_data_idle: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
		else $error("prdata outside read");
	a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_unmapped_err: assert property (acc && !hit |-> pslverr) else $error("no error on hole");
	a_mapped_ok: assert property (acc && hit |-> !pslverr) else $error("error on register");
	a_ack_zero: assert property (acc && !pwrite && paddr == 12'h2B0 |-> prdata == 32'h0)
		else $error("ack register reads nonzero");
	a_baud_space: assert property (baud_tick |=> s_quiet)
		else $error("baud pulses too close");
endmodule // dtc_asserts

bind dtc_timers dtc_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .baud_tick(baud_tick));

//--- dv/dtc_pin_model.sv
// Far-side source of falling edges on an external count pin
`timescale 1ns/1ns
module dtc_pin_model (
	input wire pclk,
	output logic pin
);
	// Idle high, as a pulled-up count line sits between bursts
	initial pin = 1'b1;
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge pclk);
			pin <= 1'b0;
			repeat (12) @(posedge pclk);
			pin <= 1'b1;
			repeat (12) @(posedge pclk);
		end
	endtask
endmodule // dtc_pin_model

//--- dv/dtc_timers_bench.sv
// Self-checking bench for the dual timer block
`timescale 1ns/1ns
module dtc_timers_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic ext_irq0_pin = 1, ext_irq1_pin = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, r;
	logic e;
	wire [31:0] prdata;
	wire pready, pslverr, t0_irq, t1_irq, x0_req, x1_req, baud_tick, cnt_pin, cnt_pin1;
	wire [3:0] ev = {baud_tick, x0_req, t1_irq, t0_irq};
	int errors = 0, cmp_count = 0, n;
	time t_last = 0, t_prev = 0;
	// Rows: address, write data, read-back, slave error
	logic [28:0] rows [9] = '{{12'h224, 8'hA5, 8'hA5, 1'b0}, {12'h228, 8'h3C, 8'h3C, 1'b0},
		{12'h22C, 8'hC3, 8'hC3, 1'b0}, {12'h230, 8'h5A, 8'h5A, 1'b0},
		{12'h234, 8'h81, 8'h81, 1'b0}, {12'h2A0, 8'h8A, 8'h8A, 1'b0},
		{12'h2B0, 8'h00, 8'h00, 1'b0}, {12'h0F0, 8'hFF, 8'h00, 1'b1},
		{12'h220, 8'h05, 8'h05, 1'b0}};
	always #5 pclk = ~pclk;
	// Stamp each new timer 0 request to measure overflow periods
	always @(posedge t0_irq) begin
		t_prev = t_last;
		t_last = $time;
	end
	dtc_timers DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
		.timer0_count_pin(cnt_pin), .timer1_count_pin(cnt_pin1), .timer0_irq(t0_irq),
		.timer1_irq(t1_irq), .ext_irq0_req(x0_req), .ext_irq1_req(x1_req),
		.baud_tick(baud_tick));
	dtc_pin_model u_pin (.pclk(pclk), .pin(cnt_pin));
	dtc_pin_model u_pin1 (.pclk(pclk), .pin(cnt_pin1));
	task automatic wrap_up;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; leaves an idle edge so calls never collide
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			if (++n > 16) chk("pready", 1, 0);
			if (n > 16) wrap_up();
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		bus(1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		bus(0, a, 8'h0);
	endtask
	// Wait on one event line, bounded
	task automatic wt(input int b, input logic v);
		n = 0;
		while (ev[b] !== v) begin
			@(posedge pclk);
			if (++n > 2000) chk("wait", 1, 0);
			if (n > 2000) wrap_up();
		end
	endtask
	// Main sequence; every mode change is made with the timers stopped
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		foreach (rows[i]) begin
			rd(rows[i][28:17]);
			chk("reset", 0, r);
			w(rows[i][28:17], rows[i][16:9]);
			rd(rows[i][28:17]);
			chk("read", {24'h0, rows[i][8:1]}, r);
			chk("pslverr", rows[i][0], e);
		end
		w(12'h220, 8'h00);
		w(12'h224, 8'h02);
		w(12'h230, 8'hFC);
		w(12'h228, 8'hFC);
		w(12'h2A0, 8'h02);
		w(12'h220, 8'h10);
		repeat (40) @(posedge pclk);
		rd(12'h220);
		chk("flag", 32'h30, r);
		chk("masked", 0, t0_irq);
		w(12'h2A0, 8'h82);
		chk("irq", 1, t0_irq);
		w(12'h220, 8'h20);
		rd(12'h230);
		chk("high", 32'hFC, r);
		w(12'h2B0, 8'h02);
		chk("ack", 0, t0_irq);
		w(12'h220, 8'h10);
		for (int k = 0; k < 4; k++) begin
			wt(0, 1);
			if (k == 1) w(12'h230, 8'hF0);
			w(12'h2B0, 8'h02);
			if (k == 1) chk("period", 32'hF0, t_last - t_prev);
			if (k == 3) chk("period", 32'h3C0, t_last - t_prev);
		end
		// Both timers count falling edges from their own pin models
		w(12'h220, 8'h00);
		w(12'h224, 8'h55);
		w(12'h228, 8'hFE);
		w(12'h230, 8'h00);
		w(12'h22C, 8'h00);
		w(12'h220, 8'h50);
		fork
			u_pin.pulses(3);
			u_pin1.pulses(3);
		join
		repeat (24) @(posedge pclk);
		rd(12'h228);
		chk("count", 1, r);
		rd(12'h230);
		chk("carry", 1, r);
		rd(12'h22C);
		chk("count 1", 3, r);
		w(12'h220, 8'h00);
		w(12'h224, 8'h90);
		w(12'h22C, 8'h00);
		ext_irq1_pin <= 0;
		w(12'h220, 8'h40);
		repeat (30) @(posedge pclk);
		rd(12'h22C);
		chk("gated", 0, r);
		ext_irq1_pin <= 1;
		repeat (30) @(posedge pclk);
		rd(12'h22C);
		chk("ungated", 1, r != 0);
		w(12'h220, 8'h00);
		w(12'h228, 8'h00);
		w(12'h230, 8'h00);
		w(12'h22C, 8'h10);
		w(12'h224, 8'hB3);
		ext_irq1_pin <= 0;
		w(12'h220, 8'h40);
		repeat (60) @(posedge pclk);
		rd(12'h230);
		chk("split high", 1, r != 0);
		rd(12'h228);
		chk("split low", 0, r);
		// Gate open and run bit set: only mode 3 can hold timer 1 now
		ext_irq1_pin <= 1;
		repeat (30) @(posedge pclk);
		rd(12'h22C);
		chk("halt", 32'h10, r);
		w(12'h220, 8'h00);
		w(12'h2A0, 8'h85);
		w(12'h220, 8'h01);
		ext_irq0_pin <= 0;
		repeat (4) @(posedge pclk);
		chk("edge", 1, x0_req);
		chk("x1 idle", 0, x1_req);
		ext_irq0_pin <= 1;
		w(12'h2B0, 8'h01);
		chk("edge ack", 0, x0_req);
		w(12'h220, 8'h00);
		ext_irq0_pin <= 0;
		ext_irq1_pin <= 0;
		repeat (4) @(posedge pclk);
		chk("level", 1, x0_req);
		chk("level 1", 1, x1_req);
		w(12'h2B0, 8'h01);
		chk("level ack", 1, x0_req);
		ext_irq0_pin <= 1;
		ext_irq1_pin <= 1;
		repeat (4) @(posedge pclk);
		chk("level off", 0, x0_req);
		chk("level 1 off", 0, x1_req);
		w(12'h220, 8'h00);
		w(12'h224, 8'h20);
		w(12'h22C, 8'hFF);
		w(12'h234, 8'hFF);
		w(12'h2A0, 8'h88);
		w(12'h220, 8'h40);
		repeat (20) @(posedge pclk);
		n = 0;
		repeat (120) begin
			@(posedge pclk);
			n += baud_tick;
		end
		chk("baud", 32'h14, n);
		chk("t1 irq", 1, t1_irq);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk("baud reset", 0, baud_tick);
		rd(12'h224);
		chk("rereset", 0, r);
		wrap_up();
	end
endmodule // dtc_timers_bench

//--- pkg/dtc_defs.vh
// Register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
// Register indices; each register takes one word, so the byte address is four times these
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_T0LO 8'h8A
`define DTC_IDX_T1LO 8'h8B
`define DTC_IDX_T0HI 8'h8C
`define DTC_IDX_T1HI 8'h8D
`define DTC_IDX_IEN 8'hA8
`define DTC_IDX_ACK 8'hAC
// Byte addresses on the register bus
`define DTC_ADDR_CTRL {2'b00, `DTC_IDX_CTRL, 2'b00}
`define DTC_ADDR_MODE {2'b00, `DTC_IDX_MODE, 2'b00}
`define DTC_ADDR_T0LO {2'b00, `DTC_IDX_T0LO, 2'b00}
`define DTC_ADDR_T1LO {2'b00, `DTC_IDX_T1LO, 2'b00}
`define DTC_ADDR_T0HI {2'b00, `DTC_IDX_T0HI, 2'b00}
`define DTC_ADDR_T1HI {2'b00, `DTC_IDX_T1HI, 2'b00}
`define DTC_ADDR_IEN {2'b00, `DTC_IDX_IEN, 2'b00}
`define DTC_ADDR_ACK {2'b00, `DTC_IDX_ACK, 2'b00}
// Control register fields
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CTRL_IE1 3
`define DTC_CTRL_IT1 2
`define DTC_CTRL_IE0 1
`define DTC_CTRL_IT0 0
// Mode register fields, per-timer nibble
`define DTC_MODE_GATE 3
`define DTC_MODE_SRC 2
`define DTC_MODE_M_HI 1
`define DTC_MODE_M_LO 0
// Mode encodings
`define DTC_M13 2'b00
`define DTC_M16 2'b01
`define DTC_M8AR 2'b10
`define DTC_MSPLIT 2'b11
// Interrupt enable fields
`define DTC_IEN_EA 7
`define DTC_IEN_ET1 3
`define DTC_IEN_EX1 2
`define DTC_IEN_ET0 1
`define DTC_IEN_EX0 0
// Acknowledge register fields (write one to vector)
`define DTC_ACK_T1 3
`define DTC_ACK_X1 2
`define DTC_ACK_T0 1
`define DTC_ACK_X0 0
// Reset values
`define DTC_RST_BYTE 8'h00
// Peripheral cycle in clocks
`define DTC_PER_CLKS 3'h6
`endif

//--- rtl/dtc_timers.v
// Two timer/counters with shared control, mode and interrupt request logic
`timescale 1ns/1ns
`include "dtc_defs.vh"

// How it works
// - Timer 0 mode 2 counts low byte, overflow sets flag, reloads from high.
// - Overflow flag clears when CPU vectors to that timer interrupt.
// - High byte writes accepted anytime, used at next reload.
// - Auto-reload period is six clocks times 256 minus reload value.
// - Split mode: timer 0 low byte uses timer 0 gate, source, run, flag.
// - Split mode: high byte counts clock/6, runs on timer 1 run, sets flag 1.
// - Timer 1 in mode 3 halts and keeps its count.
// - Mode 0 is 13-bit: five-bit prescaler carries into high byte.
// - Mode 1 cascades low and high bytes into one 16-bit counter.
// - Timer 1 mode 2 counts low byte, overflow sets flag, reloads from high.
// - Gate clear: count when run set; gate set: also need interrupt pin high.
// - Source clear counts divided clock; set counts falling edges on count pin.
// - Rollover to zero sets the overflow flag, raising an interrupt request.
// - Timer interrupt needs both its enable and the global enable.
// - Run bits at control bits 6 and 4 turn timers on and off.
// - Type bits 2 and 0 choose low level or falling edge triggering.
// - External flags at bits 3, 1; hardware clear on vector only if edge.
// - Mode field: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or halt.
// - Timer 1 overflow drives the serial port baud clock.
// - Timer operation increments once per six-clock peripheral cycle.
// - Count pin sampled each peripheral cycle; high then low counts once.
module dtc_timers (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire ext_irq0_pin,
	input wire ext_irq1_pin,
	input wire timer0_count_pin,
	input wire timer1_count_pin,
	output wire timer0_irq,
	output wire timer1_irq,
	output wire ext_irq0_req,
	output wire ext_irq1_req,
	output wire baud_tick
);
	// Software-visible control, mode and enable registers
	reg [7:0] ctrl_q;
	reg [7:0] mode_q;
	reg [7:0] ien_q;

	// Count bytes of both timers
	reg [7:0] t0lo_q;
	reg [7:0] t0hi_q;
	reg [7:0] t1lo_q;
	reg [7:0] t1hi_q;

	// Prescaler, interrupt pin history and baud pulse
	reg [2:0] div_q;
	reg [1:0] pin0_q;
	reg [1:0] pin1_q;
	reg baud_q;

	// Peripheral cycle strobe and bus strobes
	wire tick;
	wire wr_en;
	wire rd_en;
	wire wr_ctrl;
	wire wr_mode;
	wire wr_ien;
	wire wr_ack;
	wire wr_t0lo;
	wire wr_t0hi;
	wire wr_t1lo;
	wire wr_t1hi;

	// Per-timer views of the mode and control fields
	wire [1:0] mode0;
	wire [1:0] mode1;
	wire split0;
	wire [1:0] inc;
	wire [1:0] xfall;
	wire [1:0] tr_bit;
	wire [1:0] xpin;
	wire [1:0] ack_t;
	wire [1:0] ack_x;

	// Next-state values
	reg [7:0] t0lo_d;
	reg [7:0] t0hi_d;
	reg [7:0] t1lo_d;
	reg [7:0] t1hi_d;
	reg [7:0] ctrl_d;
	reg ov0;
	reg ov1;
	reg addr_ok;

	// Bus handshake: zero wait states, error on unmapped address
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign pslverr = psel & penable & ~addr_ok;

	// One write strobe per register keeps the decode in a single place
	// Unmapped writes fall through every strobe and change nothing
	assign wr_ctrl = wr_en & (paddr == `DTC_ADDR_CTRL);
	assign wr_mode = wr_en & (paddr == `DTC_ADDR_MODE);
	assign wr_ien = wr_en & (paddr == `DTC_ADDR_IEN);
	assign wr_ack = wr_en & (paddr == `DTC_ADDR_ACK);
	assign wr_t0lo = wr_en & (paddr == `DTC_ADDR_T0LO);
	assign wr_t0hi = wr_en & (paddr == `DTC_ADDR_T0HI);
	assign wr_t1lo = wr_en & (paddr == `DTC_ADDR_T1LO);
	assign wr_t1hi = wr_en & (paddr == `DTC_ADDR_T1HI);

	always @* begin
		case (paddr)
			`DTC_ADDR_CTRL, `DTC_ADDR_MODE, `DTC_ADDR_T0LO, `DTC_ADDR_T1LO,
			`DTC_ADDR_T0HI, `DTC_ADDR_T1HI, `DTC_ADDR_IEN, `DTC_ADDR_ACK: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	assign mode0 = mode_q[1:0];
	assign mode1 = mode_q[5:4];
	assign tr_bit = {ctrl_q[`DTC_CTRL_TR1], ctrl_q[`DTC_CTRL_TR0]};
	assign xpin = {ext_irq1_pin, ext_irq0_pin};
	// Timer 0 split mode lends its high byte to timer 1's run bit and flag
	assign split0 = (mode0 == `DTC_MSPLIT);

	// peripheral cycle divider, one tick per six clocks
	// Free-running from reset; software cannot realign it, so a first period may be short
	assign tick = (div_q == `DTC_PER_CLKS - 3'h1);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 3'h0;
		end else if (tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Per-timer input select; pins sampled once per peripheral cycle
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_src
			wire cpin;
			wire [3:0] nib;
			reg [1:0] samp_q;
			assign cpin = (g == 0) ? timer0_count_pin : timer1_count_pin;
			assign nib = mode_q[4*g+3:4*g];
			// sample per peripheral cycle, high then low is one count
			// Cleared history cannot show a fall until a high has been sampled
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					samp_q <= 2'b00;
				end else if (tick) begin
					samp_q <= {samp_q[0], cpin};
				end
			end
			assign xfall[g] = samp_q[1] & ~samp_q[0];
			// gating by run bit and interrupt pin
			// clock or pin as the source; run bit enables
			assign inc[g] = tick & tr_bit[g] & (~nib[`DTC_MODE_GATE] | xpin[g]) &
				(nib[`DTC_MODE_SRC] ? xfall[g] : 1'b1);
		end
	endgenerate

	// Interrupt acknowledges: write-one pulses standing in for the vector cycle
	assign ack_x = {2{wr_ack}} &
		{pwdata[`DTC_ACK_X1], pwdata[`DTC_ACK_X0]};
	assign ack_t = {2{wr_ack}} &
		{pwdata[`DTC_ACK_T1], pwdata[`DTC_ACK_T0]};

	// Counter next state for both timers
	always @* begin
		t0lo_d = t0lo_q;
		t0hi_d = t0hi_q;
		t1lo_d = t1lo_q;
		t1hi_d = t1hi_q;
		ov0 = 1'b0;
		ov1 = 1'b0;
		// Timer 0
		if (inc[0]) begin
			case (mode0)
				// 13-bit, five-bit prescaler, upper three bits ignored
				`DTC_M13: begin
					t0lo_d = {t0lo_q[7:5], t0lo_q[4:0] + 5'h01};
					if (t0lo_q[4:0] == 5'h1F) begin
						t0hi_d = t0hi_q + 8'h01;
						ov0 = (t0hi_q == 8'hFF);
					end
				end
				`DTC_M16: begin
					t0lo_d = t0lo_q + 8'h01;
					if (t0lo_q == 8'hFF) begin
						t0hi_d = t0hi_q + 8'h01;
						ov0 = (t0hi_q == 8'hFF);
					end
				end
				// reload from high byte; period 6*(256-high)
				// Flag and reload share one compare, so they cannot drift apart
				`DTC_M8AR: begin
					ov0 = (t0lo_q == 8'hFF);
					t0lo_d = ov0 ? t0hi_q : t0lo_q + 8'h01;
				end
				// split mode low byte on timer 0 controls
				default: begin
					ov0 = (t0lo_q == 8'hFF);
					t0lo_d = t0lo_q + 8'h01;
				end
			endcase
		end
		// split high byte on clock/6; timer 1 run bit only
		// Timer 1 gate and pin are ignored here on purpose
		if (split0 && tick && ctrl_q[`DTC_CTRL_TR1]) begin
			t0hi_d = t0hi_q + 8'h01;
			ov1 = (t0hi_q == 8'hFF);
		end
		// Timer 1
		if (inc[1]) begin
			case (mode1)
				`DTC_M13: begin
					t1lo_d = {t1lo_q[7:5], t1lo_q[4:0] + 5'h01};
					if (t1lo_q[4:0] == 5'h1F) begin
						t1hi_d = t1hi_q + 8'h01;
						ov1 = ov1 | (t1hi_q == 8'hFF);
					end
				end
				`DTC_M16: begin
					t1lo_d = t1lo_q + 8'h01;
					if (t1lo_q == 8'hFF) begin
						t1hi_d = t1hi_q + 8'h01;
						ov1 = ov1 | (t1hi_q == 8'hFF);
					end
				end
				`DTC_M8AR: begin
					if (t1lo_q == 8'hFF) begin
						t1lo_d = t1hi_q;
						ov1 = 1'b1;
					end else begin
						t1lo_d = t1lo_q + 8'h01;
					end
				end
				// mode 3 halts timer 1, count held
				default: begin
					t1lo_d = t1lo_q;
				end
			endcase
		end
		// Software writes; high byte accepted any time. A write wins a collision with counting,
		// which only happens where software broke the stop-before-write convention.
		if (wr_t0lo) t0lo_d = pwdata[7:0];
		if (wr_t0hi) t0hi_d = pwdata[7:0];
		if (wr_t1lo) t1lo_d = pwdata[7:0];
		if (wr_t1hi) t1hi_d = pwdata[7:0];
	end

	// Control register next state; hardware set wins over any clear
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) ctrl_d = pwdata[7:0];
		if (ack_t[0]) ctrl_d[`DTC_CTRL_TF0] = 1'b0;
		if (ack_t[1]) ctrl_d[`DTC_CTRL_TF1] = 1'b0;
		// vector clears external flag only when edge triggered
		if (ack_x[0] & ctrl_q[`DTC_CTRL_IT0]) ctrl_d[`DTC_CTRL_IE0] = 1'b0;
		if (ack_x[1] & ctrl_q[`DTC_CTRL_IT1]) ctrl_d[`DTC_CTRL_IE1] = 1'b0;
		// level mode tracks pin low; edge mode latches falling edge
		// Level mode ignores the acknowledge: the flag simply follows the pin
		if (!ctrl_q[`DTC_CTRL_IT0]) ctrl_d[`DTC_CTRL_IE0] = ~pin0_q[0];
		else if (pin0_q[1] & ~pin0_q[0]) ctrl_d[`DTC_CTRL_IE0] = 1'b1;
		if (!ctrl_q[`DTC_CTRL_IT1]) ctrl_d[`DTC_CTRL_IE1] = ~pin1_q[0];
		else if (pin1_q[1] & ~pin1_q[0]) ctrl_d[`DTC_CTRL_IE1] = 1'b1;
		if (ov0) ctrl_d[`DTC_CTRL_TF0] = 1'b1;
		if (ov1) ctrl_d[`DTC_CTRL_TF1] = 1'b1;
	end

	// Registers; relies on software stopping a timer before a mode change
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `DTC_RST_BYTE;
			mode_q <= `DTC_RST_BYTE;
			ien_q <= `DTC_RST_BYTE;
			t0lo_q <= `DTC_RST_BYTE;
			t0hi_q <= `DTC_RST_BYTE;
			t1lo_q <= `DTC_RST_BYTE;
			t1hi_q <= `DTC_RST_BYTE;
			pin0_q <= 2'b11;
			pin1_q <= 2'b11;
			baud_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			t0lo_q <= t0lo_d;
			t0hi_q <= t0hi_d;
			t1lo_q <= t1lo_d;
			t1hi_q <= t1hi_d;
			pin0_q <= {pin0_q[0], ext_irq0_pin};
			pin1_q <= {pin1_q[0], ext_irq1_pin};
			// timer 1 overflow as baud clock; a split high byte overflow also passes while timer 1 counts outside mode 3
			// Registered so the serial side sees one clean pulse per overflow
			baud_q <= inc[1] & (mode1 != `DTC_MSPLIT) & ov1;
			// Mode and enable registers change only from software
			if (wr_mode) mode_q <= pwdata[7:0];
			if (wr_ien) ien_q <= pwdata[7:0];
		end
	end
	assign baud_tick = baud_q;

	// interrupt requests need per-source and global enables
	// Flags stay set while masked, so enabling later raises a pending request
	assign timer0_irq = ien_q[`DTC_IEN_EA] & ien_q[`DTC_IEN_ET0] & ctrl_q[`DTC_CTRL_TF0];
	assign timer1_irq = ien_q[`DTC_IEN_EA] & ien_q[`DTC_IEN_ET1] & ctrl_q[`DTC_CTRL_TF1];
	assign ext_irq0_req = ien_q[`DTC_IEN_EA] & ien_q[`DTC_IEN_EX0] & ctrl_q[`DTC_CTRL_IE0];
	assign ext_irq1_req = ien_q[`DTC_IEN_EA] & ien_q[`DTC_IEN_EX1] & ctrl_q[`DTC_CTRL_IE1];

	// Read mux; narrow registers sit in the low byte
	// The acknowledge register is write only and reads as zero
	always @* begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				`DTC_ADDR_CTRL: prdata[7:0] = ctrl_q;
				`DTC_ADDR_MODE: prdata[7:0] = mode_q;
				`DTC_ADDR_T0LO: prdata[7:0] = t0lo_q;
				`DTC_ADDR_T1LO: prdata[7:0] = t1lo_q;
				`DTC_ADDR_T0HI: prdata[7:0] = t0hi_q;
				`DTC_ADDR_T1HI: prdata[7:0] = t1hi_q;
				`DTC_ADDR_IEN: prdata[7:0] = ien_q;
				default: prdata = 32'h0000_0000;
			endcase
		end
	end
endmodule // dtc_timers
